/* File: adc_serial_register_port_pkg.sv */
package adc_serial_register_port_pkg;
   // ----------------------------------------------------------
   // command byte layout and register map
   // ----------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int CMD_RD_BIT = 6;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_MAIN_DATA = 4'h4;
   localparam logic [3:0] ADDR_AUX_DATA = 4'h5;
   localparam int STAT_MAIN_BIT = 0;
   localparam int STAT_AUX_BIT = 1;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam int NUM_REGS = 16;

   // ----------------------------------------------------------
   // word lengths in serial clocks
   // ----------------------------------------------------------
   localparam int BYTE_LEN = 8;
   localparam int MAIN_LEN = 24;
   localparam int AUX_LEN = 16;
   localparam int WORD_W = 24;
   localparam int NUM_CH = 2;

   // ----------------------------------------------------------
   // serial reset and timing
   // ----------------------------------------------------------
   localparam int ONES_LIM = 32;
   localparam int CLK_PERIOD_NS = 40;
   localparam int UPD_LEAD_NS = 200;
   localparam int UPD_CYC_RAW =
      (UPD_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UPD_CYC = (UPD_CYC_RAW < 1) ? 1 : UPD_CYC_RAW;

   typedef enum logic [1:0] {ST_COMM, ST_WRITE, ST_READ} link_state_t;
endpackage

/* File: adc_serial_register_port.sv */
`timescale 1ns/1ps
// What this block does
// - every access opens with a command byte written by the host
// - after reset the port waits for a command byte
// - command byte selects read or write and the target register
// - data enters on din, leaves on dout, timed by host sclk
// - ready line goes low when either converter has a new word
// - ready line goes high once the last unread data register read completes
// - ready line goes high before the output word is updated
// - active-low select gates all serial participation
// - the same result may be read again after ready rises
// - select tied low gives a plain three-wire interface
// - each converter ready state is a status register bit
// - in frame-sync use the msb appears when select falls
// - clocks while deselected shift no bits; the read word preload and the reset and crossing synchronizers use them
// - 32 consecutive ones on din reset the serial port
// - after serial reset the port waits for a command byte
// - the ones reset also restores all byte registers to defaults
// - the reset input also resets the serial port
// - output bits launch on the falling sclk edge
// - ready returns high once no unread result remains, or on a word load
module adc_serial_register_port
   import adc_serial_register_port_pkg::*;
(
   input wire logic ref_clk_in,              // system clock
   input wire logic sys_rst_in,              // sync reset, high
   input wire logic clk_en_in,               // system clock enable
   input wire logic sclk_in,                 // host serial clock
   input wire logic cs_n_in,                 // chip select, low
   input wire logic din_in,                  // serial data in
   output logic dout_out,                    // serial data out
   output logic dout_oe_out,                 // dout drive enable
   output logic rdy_n_out,                   // data ready, low
   input wire logic main_load_in,            // main word pulse
   input wire logic [MAIN_LEN-1:0] main_word_in, // main word
   input wire logic aux_load_in,             // aux word pulse
   input wire logic [AUX_LEN-1:0] aux_word_in    // aux word
);
   localparam int COMMIT_MIN = 1;
   localparam int COMMIT_MAX = 12;

   // ----------------------------------------------------------
   // declarations
   // ----------------------------------------------------------
   logic [NUM_CH-1:0] load;
   logic [WORD_W-1:0] word [NUM_CH];
   logic [NUM_CH-1:0] flag_v, busy_v, rd_evt_v, flag_l, rd_tgl;
   logic [WORD_W-1:0] data_l [NUM_CH];
   logic rdy_n;
   logic rst_s1, rst_s2, ones_hit, link_rst, rd_done;
   logic [5:0] ones_cnt;
   logic [4:0] bit_cnt, len;
   logic [WORD_W-1:0] rx_sr, next_rx, rd_word, tx_sr;
   logic cmd_rd, tx_armed;
   logic [ADDR_W-1:0] cmd_addr, sel_addr;
   logic [7:0] stat;
   logic [7:0] regs [NUM_REGS];
   link_state_t state;

   function automatic logic [4:0] reg_len(input logic [ADDR_W-1:0] a);
      if (a == ADDR_MAIN_DATA)
         return 5'(MAIN_LEN);
      else if (a == ADDR_AUX_DATA)
         return 5'(AUX_LEN);
      else
         return 5'(BYTE_LEN);
   endfunction

   function automatic logic is_data(input logic [ADDR_W-1:0] a);
      return (a == ADDR_MAIN_DATA) || (a == ADDR_AUX_DATA);
   endfunction

   // words held left aligned so every read shifts from bit 23
   assign load = {aux_load_in, main_load_in};
   assign word[0] = main_word_in;
   assign word[1] = {aux_word_in, {(WORD_W-AUX_LEN){1'b0}}};

   // ----------------------------------------------------------
   // per converter: update, ready flag and both crossings
   // ----------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_ch
      logic flag, upd_tgl, rd_s1, rd_s2, rd_s3;
      logic upd_s1, upd_s2, upd_s3, fl_s1, fl_s2;
      logic [3:0] busy;
      logic [WORD_W-1:0] pend, hold, dat;

      // load drops the flag first, word commits UPD_CYC later
      // update lead
      always_ff @(posedge ref_clk_in)
      begin
         if (sys_rst_in)
         begin
            flag <= 1'b0;
            busy <= 4'h0;
            pend <= '0;
            hold <= '0;
            upd_tgl <= 1'b0;
         end
         else if (clk_en_in)
         begin
            if (load[ch] && busy == 4'h0)
            begin
               pend <= word[ch];
               busy <= 4'(UPD_CYC);
               flag <= 1'b0;
            end
            else if (busy == 4'h1)
            begin
               hold <= pend;
               upd_tgl <= ~upd_tgl;
               flag <= 1'b1;
               busy <= 4'h0;
            end
            else if (busy != 4'h0)
               busy <= busy - 4'h1;
            else if (rd_evt_v[ch])
               flag <= 1'b0;
         end
      end

      // read-done toggle from the link, two flops then edge
      always_ff @(posedge ref_clk_in)
      begin
         if (sys_rst_in)
         begin
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rd_s3 <= 1'b0;
         end
         else if (clk_en_in)
         begin
            rd_s1 <= rd_tgl[ch];
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
         end
      end

      // hold is stable long before upd_s2 shows the toggle
      always_ff @(posedge sclk_in)
      begin
         if (rst_s2)
         begin
            upd_s1 <= 1'b0;
            upd_s2 <= 1'b0;
            upd_s3 <= 1'b0;
            fl_s1 <= 1'b0;
            fl_s2 <= 1'b0;
            dat <= '0;
         end
         else
         begin
            upd_s1 <= upd_tgl;
            upd_s2 <= upd_s1;
            upd_s3 <= upd_s2;
            fl_s1 <= flag;
            fl_s2 <= fl_s1;
            if (upd_s2 != upd_s3)
               dat <= hold;
         end
      end

      assign flag_v[ch] = flag;
      assign busy_v[ch] = (busy != 4'h0);
      assign rd_evt_v[ch] = rd_s2 ^ rd_s3;
      assign flag_l[ch] = fl_s2;
      assign data_l[ch] = dat;
   end

   // ----------------------------------------------------------
   // ready line
   // ----------------------------------------------------------
   // high once no result is unread, or on a load
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         rdy_n <= 1'b1;
      else if (clk_en_in)
         rdy_n <= !(|flag_v) || (|busy_v) || (|load);
   end
   assign rdy_n_out = rdy_n;

   // ----------------------------------------------------------
   // link side: reset sync and all-ones detector
   // ----------------------------------------------------------
   // reset input
   always_ff @(posedge sclk_in)
   begin
      rst_s1 <= sys_rst_in;
      rst_s2 <= rst_s1;
   end

   assign ones_hit = !cs_n_in && din_in && ones_cnt == 6'(ONES_LIM - 1);
   assign link_rst = rst_s2 || ones_hit;

   always_ff @(posedge sclk_in)
   begin
      if (link_rst)
         ones_cnt <= 6'h00;
      else if (!cs_n_in)
         ones_cnt <= din_in ? ones_cnt + 6'h01 : 6'h00;
   end

   assign next_rx = {rx_sr[WORD_W-2:0], din_in};
   assign cmd_rd = next_rx[CMD_RD_BIT];
   assign cmd_addr = next_rx[ADDR_W-1:0];
   assign len = reg_len(sel_addr);
   assign rd_done = !link_rst && !cs_n_in && state == ST_READ &&
                    bit_cnt == len - 5'h01;

   // ----------------------------------------------------------
   // transfer sequencer, din sampled on rising sclk
   // ----------------------------------------------------------
   // wait command
   always_ff @(posedge sclk_in)
   begin
      if (link_rst)
      begin
         state <= ST_COMM;
         bit_cnt <= 5'h00;
         rx_sr <= '0;
         sel_addr <= '0;
      end
      else if (!cs_n_in)
      begin
         rx_sr <= next_rx;
         bit_cnt <= bit_cnt + 5'h01;
         case (state)
            ST_COMM:
               if (bit_cnt == 5'(BYTE_LEN - 1))
               begin
                  bit_cnt <= 5'h00;
                  sel_addr <= cmd_addr;
                  state <= cmd_rd ? ST_READ : ST_WRITE;
               end
            ST_WRITE, ST_READ:
               if (bit_cnt == len - 5'h01)
               begin
                  bit_cnt <= 5'h00;
                  state <= ST_COMM;
               end
            default:
               state <= ST_COMM;
         endcase
      end
   end

   // reset only by the reset input so a ones reset fakes no read
   // read complete
   always_ff @(posedge sclk_in)
   begin
      if (rst_s2)
         rd_tgl <= '0;
      else if (rd_done && sel_addr == ADDR_MAIN_DATA)
         rd_tgl[0] <= ~rd_tgl[0];
      else if (rd_done && sel_addr == ADDR_AUX_DATA)
         rd_tgl[1] <= ~rd_tgl[1];
   end

   // byte registers; status and data addresses are read-only
   // defaults restored
   always_ff @(posedge sclk_in)
   begin
      if (link_rst)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            regs[i] <= REG_RESET_VAL;
      end
      else if (!cs_n_in && state == ST_WRITE &&
               bit_cnt == len - 5'h01 && !is_data(sel_addr) &&
               sel_addr != ADDR_STATUS)
         regs[sel_addr] <= next_rx[BYTE_LEN-1:0];
   end

   // ----------------------------------------------------------
   // read data and output shifter
   // ----------------------------------------------------------
   // status bits
   always_comb
   begin
      stat = 8'h00;
      stat[STAT_MAIN_BIT] = flag_l[0];
      stat[STAT_AUX_BIT] = flag_l[1];
      rd_word = {regs[sel_addr], {(WORD_W-BYTE_LEN){1'b0}}};
      if (sel_addr == ADDR_STATUS)
         rd_word = {stat, {(WORD_W-BYTE_LEN){1'b0}}};
      else if (sel_addr == ADDR_MAIN_DATA)
         rd_word = data_l[0];
      else if (sel_addr == ADDR_AUX_DATA)
         rd_word = data_l[1];
   end

   // preload even while deselected so the msb waits on select
   // falling launch
   always_ff @(negedge sclk_in)
   begin
      if (rst_s2 || state != ST_READ)
      begin
         tx_armed <= 1'b0;
         tx_sr <= '0;
      end
      else if (!tx_armed)
      begin
         tx_armed <= 1'b1;
         tx_sr <= rd_word;
      end
      else if (!cs_n_in)
         tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
   end
   assign dout_out = tx_sr[WORD_W-1];

   // select gates the driver directly: no sclk edge at select fall
   // bus release
   assign dout_oe_out = tx_armed && !cs_n_in;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   property p_rdy_load;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && |load |=> rdy_n_out;
   endproperty
   a_rdy_load: assert property (p_rdy_load)
      else $error("ready low after a word load");

   property p_rdy_low;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && |flag_v && !(|busy_v) && !(|load) |=> !rdy_n_out;
   endproperty
   a_rdy_low: assert property (p_rdy_low)
      else $error("ready high with a result waiting");

   property p_rdy_high;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && flag_v == '0 |=> rdy_n_out;
   endproperty
   a_rdy_high: assert property (p_rdy_high)
      else $error("ready low with no unread result");

   property p_commit;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && load[0] && !busy_v[0] |=>
         !flag_v[0] ##[COMMIT_MIN:COMMIT_MAX] flag_v[0];
   endproperty
   a_commit: assert property (p_commit)
      else $error("main word never committed");

   property p_rd_clear;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && rd_evt_v[0] && !busy_v[0] && !load[0]
         |=> !flag_v[0];
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("main flag kept after data read");

   property p_reset_link;
      @(posedge sclk_in) rst_s2 |=> state == ST_COMM && bit_cnt == 5'h00;
   endproperty
   a_reset_link: assert property (p_reset_link)
      else $error("reset left the port mid transfer");

   property p_ones;
      @(posedge sclk_in) disable iff (rst_s2)
      ones_hit |=> state == ST_COMM && bit_cnt == 5'h00 &&
                   ones_cnt == 6'h00;
   endproperty
   a_ones: assert property (p_ones)
      else $error("all-ones run did not reset the port");

   property p_regs_def;
      @(posedge sclk_in) disable iff (rst_s2)
      ones_hit |=> regs[1] == REG_RESET_VAL;
   endproperty
   a_regs_def: assert property (p_regs_def)
      else $error("register not restored by ones reset");

   property p_decode;
      @(posedge sclk_in) disable iff (rst_s2)
      !ones_hit && !cs_n_in && state == ST_COMM &&
         bit_cnt == 5'(BYTE_LEN - 1) |=>
         state == ($past(cmd_rd) ? ST_READ : ST_WRITE) &&
         sel_addr == $past(cmd_addr);
   endproperty
   a_decode: assert property (p_decode)
      else $error("command byte decoded wrongly");
endmodule

/* File: host_serial_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// host serial port model
// ----------------------------------------------------------
module host_serial_model
   import adc_serial_register_port_pkg::*;
(
   output logic sclk_out,       // serial clock
   output logic cs_n_out,       // chip select, low
   output logic din_out,        // data to device
   input wire logic dout_in,    // data from device
   input wire logic dout_oe_in  // device drives dout
);
   int oe_errs = 0;
   bit hold_cs = 1'b0;
   bit rd_ph = 1'b0;
   logic last = 1'b0;
   logic line;
   // a released line shows the inverse of its last value, never a guess
   assign line = dout_oe_in ? dout_in : ~last;
   // idle levels at time zero
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b1;
   end
   // clock idles high, pulses while deselected
   task automatic pulse(input int n, input logic d);
      repeat (n)
      begin
         sclk_out = 1'b0;
         din_out = d;
         #62.5;
         sclk_out = 1'b1;
         #62.5;
      end
   endtask
   // msb first, data read just before the rising edge
   task automatic shift(input logic [31:0] w, input int n, input bit fs,
                        output logic [31:0] r);
      r = '0;
      // select falls on its own time step, clear of any clock edge
      if (!fs)
      begin
         #10;
         cs_n_out = 1'b0;
         #10;
      end
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk_out = 1'b0;
         din_out = w[i];
         #10;
         // frame sync: select falls after the clock has fallen
         cs_n_out = 1'b0;
         #52.5;
         if (dout_oe_in !== rd_ph)
            oe_errs++;
         r[i] = line;
         last = line;
         sclk_out = 1'b1;
         #62.5;
      end
      if (!hold_cs)
         cs_n_out = 1'b1;
   endtask
   // command byte, then the selected word
   task automatic xfer(input logic [7:0] cmd, input logic [31:0] w,
                       input int n, input bit fs, output logic [31:0] r);
      if (!hold_cs)
         pulse(4, w[0]);
      shift(32'(cmd), BYTE_LEN, 1'b0, r);
      rd_ph = cmd[CMD_RD_BIT];
      if (fs && !hold_cs)
         pulse(3, w[1]);
      shift(w, n, fs && !hold_cs, r);
      rd_ph = 1'b0;
   endtask
   // select held low in three-wire use
   task automatic three_wire(input bit on);
      hold_cs = on;
      cs_n_out = !on;
   endtask
   // lost interface: 24 clocks, then 32 ones
   // from an idle port the ones pass through a read command, so the
   // device drives the line for ones 17 to 24 before the reset hits
   task automatic recover();
      logic [31:0] r;
      shift(32'h0, 24, 1'b0, r);
      shift(32'hFFFFFFFF, 16, 1'b0, r);
      rd_ph = 1'b1;
      shift(32'hFFFFFFFF, 8, 1'b0, r);
      rd_ph = 1'b0;
      shift(32'hFFFFFFFF, 8, 1'b0, r);
   endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// serial register port bench
// ----------------------------------------------------------
module testbench;
   import adc_serial_register_port_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic mload = 1'b0, aload = 1'b0;
   logic [23:0] mword = 24'h0;
   logic [15:0] aword = 16'h0;
   logic sclk, cs_n, din, dout, dout_oe, rdy_n;
   int errors = 0, tests_run = 0;
   logic [31:0] seed = 32'hD9FDDB0C;
   logic [7:0] regs [NUM_REGS];
   logic [23:0] ref_main = 24'h0;
   logic [15:0] ref_aux = 16'h0;
   logic [31:0] r;
   // 25 MHz system clock
   initial
      forever #20 clk = ~clk;
   adc_serial_register_port DUT (.ref_clk_in(clk), .sys_rst_in(rst),
      .clk_en_in(en), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
      .dout_out(dout), .dout_oe_out(dout_oe), .rdy_n_out(rdy_n),
      .main_load_in(mload), .main_word_in(mword), .aux_load_in(aload),
      .aux_word_in(aword));
   host_serial_model host (.sclk_out(sclk), .cs_n_out(cs_n),
      .din_out(din), .dout_in(dout), .dout_oe_in(dout_oe));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // word length and expected value by address
   function automatic int wlen(input int a);
      return a == ADDR_MAIN_DATA ? MAIN_LEN :
         a == ADDR_AUX_DATA ? AUX_LEN : BYTE_LEN;
   endfunction
   function automatic logic [31:0] expv(input int a);
      return a == ADDR_MAIN_DATA ? 32'(ref_main) :
         a == ADDR_AUX_DATA ? 32'(ref_aux) :
         a == ADDR_STATUS ? 32'h0 : 32'(regs[a]);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // status and data words take no writes
   task automatic wr(input int a, input logic [31:0] d);
      host.xfer(8'(a), d, wlen(a), 1'b0, r);
      if (a != ADDR_STATUS && a != ADDR_MAIN_DATA && a != ADDR_AUX_DATA)
         regs[a] = d[7:0];
   endtask
   task automatic rd(input int a, input bit fs);
      host.xfer(8'(a) | (8'h01 << CMD_RD_BIT), rnd(), wlen(a), fs, r);
   endtask
   // the link side needs sclk edges while reset is high
   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      fork
         repeat (12) @(posedge clk);
         host.pulse(3, 1'b0);
      join
      @(negedge clk);
      rst = 1'b0;
      foreach (regs[i])
         regs[i] = REG_RESET_VAL;
      check(32'(rdy_n), 32'h1);
   endtask
   task automatic load(input bit ch);
      @(negedge clk);
      mword = 24'(rnd());
      aword = 16'(rnd());
      mload = !ch;
      aload = ch;
      if (ch)
         ref_aux = aword;
      else
         ref_main = mword;
      @(negedge clk);
      mload = 1'b0;
      aload = 1'b0;
      @(negedge clk);
      check(32'(rdy_n), 32'h1);
      for (int i = 0; i < 20 && rdy_n !== 1'b0; i++)
         @(negedge clk);
      check(32'(rdy_n), 32'h0);
   endtask
   // main sequence; a wait that runs out shows as a mismatch
   initial
   begin
      do_reset();
      rd(ADDR_STATUS, 1'b0);
      check(r, 32'h0);
      // a frozen block must ignore a load pulse
      @(negedge clk);
      en = 1'b0;
      mload = 1'b1;
      @(negedge clk);
      mload = 1'b0;
      repeat (8) @(negedge clk);
      en = 1'b1;
      check(32'(rdy_n), 32'h1);
      load(1'b0);
      load(1'b1);
      rd(ADDR_STATUS, 1'b0);
      check(r, 32'((1 << STAT_MAIN_BIT) | (1 << STAT_AUX_BIT)));
      rd(ADDR_MAIN_DATA, 1'b0);
      check(r, 32'(ref_main));
      repeat (10) @(negedge clk);
      check(32'(rdy_n), 32'h0);
      rd(ADDR_AUX_DATA, 1'b0);
      check(r, 32'(ref_aux));
      repeat (10) @(negedge clk);
      check(32'(rdy_n), 32'h1);
      rd(ADDR_MAIN_DATA, 1'b1);
      check(r, 32'(ref_main));
      for (int a = 0; a < NUM_REGS; a++)
         wr(a, rnd());
      for (int a = 0; a < NUM_REGS; a++)
      begin
         rd(a, 1'b0);
         check(r, expv(a));
      end
      @(negedge clk);
      host.three_wire(1'b1);
      wr(7, rnd());
      rd(7, 1'b0);
      check(r, expv(7));
      // recovery runs with select still held low, as in three-wire use
      host.recover();
      host.three_wire(1'b0);
      foreach (regs[i])
         regs[i] = REG_RESET_VAL;
      rd(7, 1'b0);
      check(r, expv(7));
      wr(9, rnd());
      do_reset();
      rd(9, 1'b0);
      check(r, expv(9));
      check(32'(host.oe_errs), 32'h0);
      finish_test();
   end
endmodule
